// *** timekeeping_pkg.sv ***
// Shared constants and carrier types for the divider, watchdog and timer 0 block.
// Assumes one system oscillator clock and a core that issues one-cycle operation strobes.
package timekeeping_pkg;

	// Divider geometry and prescale taps (carry into stage N gives Fosc/2^N)
	localparam int DIV_WIDTH = 14;
	localparam int DIV_CLEAR_LSB = 10;
	localparam int TAP_FOSC_4 = 2;
	localparam int TAP_FOSC_1024 = 10;
	localparam int TAP_FOSC_16384 = 14;
	localparam logic [13:0] DIV_RESET = 14'h0000;
	localparam logic [13:0] DIV_ALL_ONES = 14'h3FFF;

	// Watchdog
	localparam int WDT_WIDTH = 4;
	localparam logic [3:0] WDT_RESET = 4'h0;
	localparam logic [3:0] WDT_LAST = 4'hF;

	// Parameter flag register
	localparam int PARAM_WIDTH = 4;
	localparam int PARAM_WDOG_SEL_BIT = 3;
	localparam logic [3:0] PARAM_RESET = 4'h0;

	// Timer 0 mode bits and counter
	localparam int T0_WIDTH = 8;
	localparam int MODE_PRESCALE_BIT = 0;
	localparam int MODE_RUN_BIT = 3;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [7:0] T0_RESET = 8'h00;
	localparam logic [7:0] T0_UNDERFLOW = 8'hFF;
	localparam logic [7:0] T0_ZERO = 8'h00;

	// Event flag positions
	localparam int FLAG_WIDTH = 2;
	localparam int FLAG_DIV_BIT = 0;
	localparam int FLAG_T0_BIT = 1;
	localparam logic [1:0] FLAG_RESET = 2'h0;

	// One-cycle operation strobes from the instruction decoder
	typedef struct packed {
		logic watchdog_clear_op;
		logic divider_clear_op;
		logic param_set;
		logic param_clear;
		logic [3:0] param_mask;
		logic mode_write;
		logic [3:0] mode_data;
		logic low_nibble_write;
		logic high_nibble_write;
		logic imm_write;
		logic [7:0] write_data;
		logic [1:0] event_clear;
	} op_s;

endpackage : timekeeping_pkg

// *** prescale_divider.sv ***
// Free-running 14-bit prescale divider with clearable top stages.
// Assumes the same clock and reset as the block that instantiates it.
module prescale_divider (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic divider_clear_op,
	// State and prescale taps
	output logic [timekeeping_pkg::DIV_WIDTH-1:0] count,
	output logic [timekeeping_pkg::DIV_WIDTH:0] carry
);
	import timekeeping_pkg::*;

	// Carry into each stage; carry[N] pulses once per 2^N clocks
	assign carry[0] = 1'b1;
	genvar i;
	generate
		for (i = 0; i < DIV_WIDTH; i++) begin : g_stage
			assign carry[i+1] = carry[i] & count[i];
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= DIV_RESET;
		end else begin
			count <= count + 14'h0001;
			if (divider_clear_op) begin
				count[DIV_WIDTH-1:DIV_CLEAR_LSB] <= 4'h0;
			end
		end
	end

endmodule : prescale_divider

// *** divider_watchdog_timer0.sv ***
// Divider event source, watchdog counter and one-shot timer 0 of a small controller.
// Assumes the core decodes instructions into one-cycle strobes on clk, and that
// watchdog_reset_q is routed back into the chip-wide reset.
module divider_watchdog_timer0 (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Operation strobes from the core
	input timekeeping_pkg::op_s op,
	// Enable registers held by the core
	input wire logic [timekeeping_pkg::FLAG_WIDTH-1:0] interrupt_enable_flags,
	input wire logic [timekeeping_pkg::FLAG_WIDTH-1:0] hold_release_enable_flags,
	// Watchdog code option, a static strap
	input wire logic watchdog_option,
	// Events and requests
	output logic [timekeeping_pkg::FLAG_WIDTH-1:0] event_flags_q,
	output logic [timekeeping_pkg::FLAG_WIDTH-1:0] int_request_q,
	output logic hold_release_q,
	output logic watchdog_reset_q,
	// Timer 0 state
	output logic [timekeeping_pkg::T0_WIDTH-1:0] timer0_count_q
);
	import timekeeping_pkg::*;

	logic [DIV_WIDTH-1:0] div_count;
	logic [DIV_WIDTH:0] div_carry;
	logic div_overflow;
	logic wdt_opt_meta_q;
	logic wdt_opt_q;
	logic [PARAM_WIDTH-1:0] parameter_flags_q;
	logic [WDT_WIDTH-1:0] watchdog_counter_q;
	logic wdt_tick;
	logic [3:0] timer0_mode_bits_q;
	logic t0_tick;
	logic t0_underflow;
	logic t0_start;
	logic t0_stop_load;

	// one oscillator phase per clk; machine cycle is Fosc/4 tap
	prescale_divider u_divider (
		.clk(clk),
		.reset_n(reset_n),
		.divider_clear_op(op.divider_clear_op),
		.count(div_count),
		.carry(div_carry)
	);

	// overflow only at full 14-bit wrap; a clear in the same cycle wins
	assign div_overflow = div_carry[DIV_WIDTH] & ~op.divider_clear_op;

	// Strap resynchronised; only the second stage is read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_opt_meta_q <= 1'b0;
			wdt_opt_q <= 1'b0;
		end else begin
			wdt_opt_meta_q <= watchdog_option;
			wdt_opt_q <= wdt_opt_meta_q;
		end
	end

	// write-only flags, set or clear by mask; reserved bits inert
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			parameter_flags_q <= PARAM_RESET;
		end else if (op.param_set) begin
			parameter_flags_q <= parameter_flags_q | op.param_mask;
		end else if (op.param_clear) begin
			parameter_flags_q <= parameter_flags_q & ~op.param_mask;
		end
	end

	// watchdog rate from divider taps, chosen by flag bit three
	// Both rates come from one divider, so a switch may lengthen or shorten one period
	assign wdt_tick = parameter_flags_q[PARAM_WDOG_SEL_BIT] ? div_carry[TAP_FOSC_16384] : div_carry[TAP_FOSC_1024];

	// counter held at zero while option is off
	// clear op zeroes counter, ahead of any tick
	// A clear and a tick in one cycle leave zero: software has just served it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_counter_q <= WDT_RESET;
		end else if (!wdt_opt_q || op.watchdog_clear_op) begin
			watchdog_counter_q <= WDT_RESET;
		end else if (wdt_tick) begin
			watchdog_counter_q <= watchdog_counter_q + 4'h1;
		end
	end

	// one-cycle chip reset request on wrap
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_reset_q <= 1'b0;
		end else begin
			watchdog_reset_q <= wdt_opt_q & ~op.watchdog_clear_op & wdt_tick & (watchdog_counter_q == WDT_LAST);
		end
	end

	// prescale tap; ticks align to the free divider, so the first period may be short
	assign t0_tick = timer0_mode_bits_q[MODE_PRESCALE_BIT] ? div_carry[TAP_FOSC_1024] : div_carry[TAP_FOSC_4];
	assign t0_stop_load = op.low_nibble_write | op.high_nibble_write | op.imm_write;
	assign t0_start = op.mode_write & op.mode_data[MODE_RUN_BIT] & ~t0_stop_load;
	assign t0_underflow = timer0_mode_bits_q[MODE_RUN_BIT] & t0_tick & (timer0_count_q == T0_ZERO);

	// mode bits written whole; bits one and two kept but unused
	// a load drops the run bit
	// underflow drops the run bit, no reload
	// reset leaves timer stopped at divide by four
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_mode_bits_q <= MODE_RESET;
		end else if (t0_stop_load) begin
			timer0_mode_bits_q[MODE_RUN_BIT] <= 1'b0;
		end else if (op.mode_write) begin
			timer0_mode_bits_q <= op.mode_data;
		end else if (t0_underflow) begin
			timer0_mode_bits_q[MODE_RUN_BIT] <= 1'b0;
		end
	end

	// nibble or immediate load, else count down
	// preset plus one ticks reach FFH
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_count_q <= T0_RESET;
		end else if (op.imm_write) begin
			timer0_count_q <= op.write_data;
		end else if (op.low_nibble_write) begin
			timer0_count_q[3:0] <= op.write_data[3:0];
		end else if (op.high_nibble_write) begin
			timer0_count_q[7:4] <= op.write_data[3:0];
		end else if (timer0_mode_bits_q[MODE_RUN_BIT] && t0_tick) begin
			timer0_count_q <= timer0_count_q - 8'h01;
		end
	end

	// flags sticky; a set beats a clear so no event is lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			event_flags_q <= FLAG_RESET;
		end else begin
			if (div_overflow) begin
				event_flags_q[FLAG_DIV_BIT] <= 1'b1;
			end else if (op.event_clear[FLAG_DIV_BIT]) begin
				event_flags_q[FLAG_DIV_BIT] <= 1'b0;
			end
			if (t0_underflow) begin
				event_flags_q[FLAG_T0_BIT] <= 1'b1;
			end else if (t0_start || op.event_clear[FLAG_T0_BIT]) begin
				event_flags_q[FLAG_T0_BIT] <= 1'b0;
			end
		end
	end

	// divider event gated by enable bit zero
	// timer event gated by enable bit one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			int_request_q <= FLAG_RESET;
			hold_release_q <= 1'b0;
		end else begin
			int_request_q <= event_flags_q & interrupt_enable_flags;
			hold_release_q <= |(event_flags_q & hold_release_enable_flags);
		end
	end

	// Checks on the divider, watchdog and timer; reset values are checked by the bench
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Divider checks
	// one step per clock
	div_count_step_a: assert property (!op.divider_clear_op |=> div_count == $past(div_count) + 14'h0001)
		else $error("divider missed a step");
	div_clear_keep_a: assert property (op.divider_clear_op |=> div_count[13:10] == 4'h0 &&
		div_count[9:0] == $past(div_count[9:0]) + 10'h001) else $error("divider clear disturbed low stages");
	div_overflow_a: assert property (div_count == DIV_ALL_ONES && !op.divider_clear_op |=>
		event_flags_q[FLAG_DIV_BIT] ##1 int_request_q[FLAG_DIV_BIT] == $past(interrupt_enable_flags[FLAG_DIV_BIT]))
		else $error("divider overflow lost");
	div_no_event_a: assert property (!event_flags_q[FLAG_DIV_BIT] && !div_overflow |=>
		!event_flags_q[FLAG_DIV_BIT]) else $error("divider flag rose without overflow");
	div_flag_clear_a: assert property (op.event_clear[FLAG_DIV_BIT] && !div_overflow |=>
		!event_flags_q[FLAG_DIV_BIT]) else $error("divider flag clear ignored");

	// Parameter flag and watchdog checks
	// mask set ors bits in
	param_set_a: assert property (op.param_set |=>
		parameter_flags_q == $past(parameter_flags_q | op.param_mask)) else $error("parameter set wrong");
	param_clear_a: assert property (op.param_clear && !op.param_set |=>
		parameter_flags_q == $past(parameter_flags_q & ~op.param_mask)) else $error("parameter clear wrong");
	wdt_disabled_a: assert property (!wdt_opt_q |=> watchdog_counter_q == WDT_RESET)
		else $error("watchdog counted while disabled");
	wdt_hold_a: assert property (wdt_opt_q && !op.watchdog_clear_op && !wdt_tick |=>
		$stable(watchdog_counter_q)) else $error("watchdog moved between ticks");
	wdt_step_a: assert property (wdt_opt_q && !op.watchdog_clear_op && wdt_tick |=>
		watchdog_counter_q == $past(watchdog_counter_q) + 4'h1) else $error("watchdog step wrong");
	wdt_clear_a: assert property (op.watchdog_clear_op |=> watchdog_counter_q == WDT_RESET && !watchdog_reset_q)
		else $error("watchdog clear ignored");
	wdt_overflow_a: assert property (wdt_opt_q && !op.watchdog_clear_op && wdt_tick && watchdog_counter_q == WDT_LAST
		|=> watchdog_reset_q && watchdog_counter_q == WDT_RESET) else $error("watchdog overflow missed");
	wdt_rate_a: assert property (wdt_tick |-> (parameter_flags_q[3] ? div_count == DIV_ALL_ONES
		: div_count[9:0] == 10'h3FF)) else $error("watchdog tick at wrong rate");

	// Timer 0 checks
	// immediate load, timer stopped
	t0_imm_load_a: assert property (op.imm_write |=>
		timer0_count_q == $past(op.write_data) && !timer0_mode_bits_q[MODE_RUN_BIT]) else $error("immediate load failed");
	t0_load_stop_a: assert property (op.low_nibble_write && !op.imm_write |=>
		!timer0_mode_bits_q[MODE_RUN_BIT] && timer0_count_q[3:0] == $past(op.write_data[3:0])) else $error("nibble load failed");
	t0_high_nibble_a: assert property (op.high_nibble_write && !op.imm_write && !op.low_nibble_write |=>
		!timer0_mode_bits_q[MODE_RUN_BIT] && timer0_count_q[7:4] == $past(op.write_data[3:0]))
		else $error("high nibble load failed");
	t0_load_run_a: assert property (t0_stop_load |=> !timer0_mode_bits_q[MODE_RUN_BIT])
		else $error("load left timer running");
	t0_mode_write_a: assert property (op.mode_write && !t0_stop_load |=>
		timer0_mode_bits_q == $past(op.mode_data)) else $error("mode write lost");
	t0_start_a: assert property (t0_start && !t0_underflow |=> timer0_mode_bits_q[MODE_RUN_BIT] &&
		!event_flags_q[FLAG_T0_BIT]) else $error("timer start failed");
	t0_underflow_a: assert property (t0_underflow && !op.mode_write && !t0_stop_load |=>
		timer0_count_q == T0_UNDERFLOW && !timer0_mode_bits_q[MODE_RUN_BIT] && event_flags_q[FLAG_T0_BIT])
		else $error("timer underflow wrong");
	t0_stopped_a: assert property (!timer0_mode_bits_q[MODE_RUN_BIT] && !t0_stop_load |=>
		$stable(timer0_count_q)) else $error("stopped timer moved");
	t0_fast_rate_a: assert property (timer0_mode_bits_q[3] && !timer0_mode_bits_q[0] && timer0_count_q == 8'h05 &&
		!t0_stop_load && !op.mode_write && div_count[1:0] == 2'h0 |=> timer0_count_q == 8'h05 [*3] ##1 timer0_count_q == 8'h04)
		else $error("divide by four rate wrong");
	t0_slow_rate_a: assert property (timer0_mode_bits_q[MODE_RUN_BIT] &&
		timer0_mode_bits_q[MODE_PRESCALE_BIT] && !t0_stop_load && div_count[9:0] != 10'h3FF |=>
		$stable(timer0_count_q)) else $error("divide by 1024 rate wrong");

	// Flag and request checks
	// flag zero sticky
	flag_sticky_a: assert property (event_flags_q[FLAG_DIV_BIT] && !op.event_clear[FLAG_DIV_BIT] |=>
		event_flags_q[FLAG_DIV_BIT]) else $error("divider flag dropped");
	int_divider_a: assert property (int_request_q[FLAG_DIV_BIT] ==
		$past(event_flags_q[FLAG_DIV_BIT] & interrupt_enable_flags[FLAG_DIV_BIT])) else $error("divider request wrong");
	int_timer_a: assert property (int_request_q[FLAG_T0_BIT] ==
		$past(event_flags_q[FLAG_T0_BIT] & interrupt_enable_flags[FLAG_T0_BIT])) else $error("timer request wrong");
	hold_divider_a: assert property (event_flags_q[FLAG_DIV_BIT] && hold_release_enable_flags[FLAG_DIV_BIT] |=>
		hold_release_q) else $error("divider hold release missing");
	hold_release_a: assert property (event_flags_q[FLAG_T0_BIT] && hold_release_enable_flags[FLAG_T0_BIT] |=>
		hold_release_q) else $error("hold release missing");
	hold_none_a: assert property ((event_flags_q & hold_release_enable_flags) == 2'h0 |=> !hold_release_q)
		else $error("hold release without event");

	// Scenario covers
	div_event_c: cover property (div_overflow);
	wdt_reset_c: cover property (watchdog_reset_q);
	wdt_slow_c: cover property (wdt_tick && parameter_flags_q[PARAM_WDOG_SEL_BIT]);
	t0_oneshot_c: cover property (t0_start ##[1:1000] t0_underflow);
	t0_slow_c: cover property (t0_underflow && timer0_mode_bits_q[MODE_PRESCALE_BIT]);

endmodule : divider_watchdog_timer0

// *** testbench.sv ***
// Self-checking bench for the divider, watchdog and timer 0 block.
// Assumes the package is compiled first; all strobes are driven at the falling edge.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timekeeping_pkg::*;

	// Stimulus and observed signals
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	op_s op = '0;
	logic [1:0] interrupt_enable_flags = 2'b10;
	logic [1:0] hold_release_enable_flags = 2'b01;
	logic watchdog_option = 1'b0;
	logic [1:0] event_flags_q;
	logic [1:0] int_request_q;
	logic hold_release_q;
	logic watchdog_reset_q;
	logic [7:0] timer0_count_q;
	logic wd_seen = 1'b0;
	int failures = 0;
	int tests_run = 0;
	int n;
	int i;

	// 100 MHz clock
	always #5 clk = ~clk;

	divider_watchdog_timer0 dut (
		.clk(clk),
		.reset_n(reset_n),
		.op(op),
		.interrupt_enable_flags(interrupt_enable_flags),
		.hold_release_enable_flags(hold_release_enable_flags),
		.watchdog_option(watchdog_option),
		.event_flags_q(event_flags_q),
		.int_request_q(int_request_q),
		.hold_release_q(hold_release_q),
		.watchdog_reset_q(watchdog_reset_q),
		.timer0_count_q(timer0_count_q)
	);

	// Sticky record of any chip reset request, since the pulse lasts one cycle
	always @(negedge clk) begin
		if (watchdog_reset_q === 1'b1) begin
			wd_seen = 1'b1;
		end
	end

	task automatic report_and_stop();
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Measured cycle counts only, never design values
	task automatic check_range(input int got, input int lo, input int hi, input string what);
		tests_run++;
		if (got < lo || got > hi) begin
			failures++;
			$display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, got);
		end
	endtask : check_range

	// One-cycle strobe: raised at one falling edge, dropped at the next
	task automatic issue(input op_s o);
		@(negedge clk);
		op = o;
		@(negedge clk);
		op = '0;
	endtask : issue

	// Kinds: 0 load, 1 mode, 2 low nibble, 3 high nibble, 4 param set, 5 param clear,
	// 6 watchdog clear, 7 divider clear, 8 event clear
	task automatic do_op(input int kind, input logic [7:0] v);
		op_s o;
		o = '0;
		o.write_data = v;
		o.mode_data = v[3:0];
		o.param_mask = 4'h8;
		o.imm_write = (kind == 0);
		o.mode_write = (kind == 1);
		o.low_nibble_write = (kind == 2);
		o.high_nibble_write = (kind == 3);
		o.param_set = (kind == 4);
		o.param_clear = (kind == 5);
		o.watchdog_clear_op = (kind == 6);
		o.divider_clear_op = (kind == 7);
		o.event_clear = (kind == 8) ? 2'b11 : 2'b00;
		issue(o);
	endtask : do_op

	// Bounded wait on event flag sel (0, 1) or the chip reset request (2)
	task automatic wait_sig(input int sel, input int lim, input bit must, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (cnt < lim && !hit) begin
			@(negedge clk);
			cnt++;
			hit = (sel == 2) ? (watchdog_reset_q === 1'b1) : (event_flags_q[sel] === 1'b1);
		end
		tests_run++;
		if (hit !== must) begin
			failures++;
			$display("CHECK FAILED at %0t: wait on source %0d ended wrongly", $time, sel);
			if (must) begin
				report_and_stop();
			end
		end
	endtask : wait_sig

	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		check({event_flags_q, int_request_q, hold_release_q, watchdog_reset_q, timer0_count_q}, 16'h0000, "reset");
		// Timer 0 one-shot at Fosc/4
		do_op(0, 8'h05);
		check(timer0_count_q, 16'h0005, "immediate load");
		do_op(1, 8'h08);
		check(event_flags_q[1], 16'h0000, "start clears flag");
		wait_sig(1, 40, 1'b1, n);
		check_range(n, 20, 26, "fosc4 interval");
		check(timer0_count_q, 16'h00FF, "underflow value");
		@(negedge clk);
		check({int_request_q, hold_release_q}, 16'h0004, "timer requests");
		repeat (8) @(negedge clk);
		check({event_flags_q[1], timer0_count_q}, 16'h01FF, "stopped and sticky");
		// Timer 0 at Fosc/1024, restart clears the old flag
		do_op(0, 8'h01);
		do_op(1, 8'h09);
		check(event_flags_q[1], 16'h0000, "restart clears flag");
		wait_sig(1, 2200, 1'b1, n);
		check_range(n, 1024, 2052, "fosc1024 interval");
		// A low nibble write halts a running count; the high nibble is then written while stopped
		do_op(0, 8'h80);
		do_op(1, 8'h09);
		do_op(2, 8'h0A);
		check(timer0_count_q[3:0], 16'h000A, "low nibble");
		repeat (1100) @(negedge clk);
		do_op(3, 8'h03);
		check(timer0_count_q, 16'h003A, "halted count");
		// Divider overflow and clear of its top stages
		wait_sig(0, 16400, 1'b1, n);
		@(negedge clk);
		check({int_request_q, hold_release_q}, 16'h0001, "divider requests");
		do_op(8, 8'h00);
		check(event_flags_q, 16'h0000, "software clear");
		repeat (2000) @(negedge clk);
		do_op(7, 8'h00);
		wait_sig(0, 16000, 1'b1, n);
		check_range(n, 15397, 15409, "divider period after clear");
		// Watchdog: disabled so far, then both clock selects
		check(wd_seen, 16'h0000, "watchdog disabled");
		watchdog_option = 1'b1;
		do_op(6, 8'h00);
		do_op(4, 8'h00);
		wait_sig(2, 18000, 1'b0, n);
		do_op(5, 8'h00);
		wait_sig(2, 17500, 1'b1, n);
		for (i = 0; i < 18; i++) begin
			do_op(6, 8'h00);
			wait_sig(2, 1000, 1'b0, n);
		end
		report_and_stop();
	end
endmodule : testbench
